//--- src/rpdn_dev.sv
// Adapter end: remote pipe descriptor tail and notification block emitter.
// Assumes the host end drives the descriptor port and accepts notice bytes.
//
// What this design does
// - host keeps multi translator bit clear if unsupported
// - capability bits report control iso bulk interrupt
// - bit four flags transparent pipe, top reserved
// - capability byte is read only
// - retry limit in bits 2:0, 0 to 3
// - zero retry limit means unlimited, no counting
// - host writes zero retry limit for isochronous
// - count transaction errors in sixteen bit counter
// - only host clears error counter
// - vendor word is free for vendor use
// - zero result endpoint means default results endpoint
// - host names only implemented result endpoints
// - result endpoint reserved zero on transparent pipes
// - writable fields take host written values
// - notices go out on results endpoint
// - armed wake emits length two, code 91
// - port change emits length three, 92, port
// - multi translator flag only valid conditionally
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module rpdn_dev (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  rpdn_if.dev bus,
  input wire logic [rpdn_pkg::RPDN_CAP_TRANSP:0] i_caps,
  input wire logic i_wake_armed,
  input wire logic i_wake_event,
  input wire logic i_port_change,
  input wire logic [7:0] i_port_index,
  input wire logic i_txn_error,
  input wire logic i_hs_hub_nonzero,
  input wire logic i_high_speed,
  input wire logic [7:0] i_result_eps,
  output logic [2:0] o_retry_limit,
  output logic o_count_errors,
  output logic [7:0] o_result_ep,
  output logic o_use_default_ep,
  output logic o_behind_mtt,
  output logic [15:0] o_vendor_word
);
  import rpdn_pkg::*;

  typedef struct packed {
    logic [7:0] retry;
    logic [15:0] errs;
    logic [15:0] vend;
    logic [7:0] resep;
    logic [7:0] attr;
    logic [7:0] rdata;
    logic wake_pend;
    logic port_pend;
    logic [7:0] port_idx;
    logic [7:0] emit_idx;
    rpdn_emit_e emit;
    logic emit_port;
    logic [7:0] nbyte;
    logic nvalid;
    logic nlast;
    logic [2:0] retry_o;
    logic cnt_o;
    logic [7:0] ep_o;
    logic def_o;
    logic mtt_o;
  } rpdn_dev_s;

  rpdn_dev_s s_q;
  rpdn_dev_s s_d;
  logic [7:0] caps;

  // Retry limit field of a stored options byte; the reserved bits are cut off.
  function automatic logic [2:0] retry_field(input logic [7:0] opts);
    return 3'(opts & RPDN_RETRY_MASK);
  endfunction : retry_field

  // Capability byte comes from hardware straps, reserved bits zero.
  assign caps = {3'h0, i_caps};

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic for descriptor, counter and notice emitter.
  always_comb begin
    s_d = s_q;
    // Descriptor reads return the addressed byte one cycle later.
    if (bus.desc_rd) begin
      if (bus.desc_addr == RPDN_OFF_CAPS) begin
        s_d.rdata = caps;
      end else if (bus.desc_addr == RPDN_OFF_RETRY) begin
        s_d.rdata = s_q.retry;
      end else if (bus.desc_addr == RPDN_OFF_ERR_LO) begin
        s_d.rdata = s_q.errs[7:0];
      end else if (bus.desc_addr == RPDN_OFF_ERR_HI) begin
        s_d.rdata = s_q.errs[15:8];
      end else if (bus.desc_addr == RPDN_OFF_VEND_LO) begin
        s_d.rdata = s_q.vend[7:0];
      end else if (bus.desc_addr == RPDN_OFF_VEND_HI) begin
        s_d.rdata = s_q.vend[15:8];
      end else if (bus.desc_addr == RPDN_OFF_RES_EP) begin
        s_d.rdata = s_q.resep;
      end else if (bus.desc_addr == RPDN_OFF_ATTR) begin
        s_d.rdata = s_q.attr;
      end else begin
        s_d.rdata = RPDN_RST_BYTE;
      end
    end
    // Hardware error counting; a zero limit disables it, the top value holds.
    if (i_txn_error && (retry_field(s_q.retry) != 3'h0) && (s_q.errs != RPDN_ERR_SAT)) begin
      s_d.errs = s_q.errs + RPDN_ONE16;
    end
    // Host writes adopt new values; the capability byte ignores them.
    if (bus.desc_wr) begin
      if (bus.desc_addr == RPDN_OFF_RETRY) begin
        s_d.retry = bus.desc_wdata & RPDN_RETRY_MASK;
      end else if (bus.desc_addr == RPDN_OFF_ERR_LO) begin
        s_d.errs[7:0] = bus.desc_wdata;
      end else if (bus.desc_addr == RPDN_OFF_ERR_HI) begin
        s_d.errs[15:8] = bus.desc_wdata;
      end else if (bus.desc_addr == RPDN_OFF_VEND_LO) begin
        s_d.vend[7:0] = bus.desc_wdata;
      end else if (bus.desc_addr == RPDN_OFF_VEND_HI) begin
        s_d.vend[15:8] = bus.desc_wdata;
      end else if (bus.desc_addr == RPDN_OFF_RES_EP) begin
        s_d.resep = bus.desc_wdata;
      end else if (bus.desc_addr == RPDN_OFF_ATTR) begin
        s_d.attr = bus.desc_wdata;
      end // Capability offset falls through untouched.
    end
    // Derived settings for the transfer engines.
    s_d.retry_o = (retry_field(s_q.retry) > RPDN_RETRY_MAX) ? RPDN_RETRY_MAX :
                  retry_field(s_q.retry);
    s_d.cnt_o = (retry_field(s_q.retry) != 3'h0);
    // Transparent pipes ignore the result endpoint; unknown ones fall back.
    s_d.def_o = caps[RPDN_CAP_TRANSP] || (s_q.resep == RPDN_RST_BYTE) ||
                !i_result_eps[s_q.resep[2:0]];
    s_d.ep_o = s_d.def_o ? RPDN_RST_BYTE : s_q.resep;
    s_d.mtt_o = s_q.attr[RPDN_ATTR_MTT] && i_hs_hub_nonzero && !i_high_speed;
    // Pending events; a new event wins over the clear at emission start.
    if (s_q.emit == RPDN_IDLE && !s_q.nvalid) begin
      if (s_q.wake_pend) begin
        s_d.wake_pend = 1'b0;
        s_d.emit_port = 1'b0;
        s_d.emit = RPDN_B0;
      end else if (s_q.port_pend) begin
        s_d.port_pend = 1'b0;
        s_d.emit_port = 1'b1;
        // The block keeps its own index, so a later change cannot alter it mid-block.
        s_d.emit_idx = s_q.port_idx;
        s_d.emit = RPDN_B0;
      end
    end
    if (i_wake_event && i_wake_armed) begin
      s_d.wake_pend = 1'b1;
    end
    if (i_port_change) begin
      s_d.port_pend = 1'b1;
      s_d.port_idx = i_port_index;
    end
    // Byte emitter: a block leaves whole, one byte per accepted handshake.
    if (s_q.nvalid && bus.note_ready) begin
      s_d.nvalid = 1'b0;
    end
    if (!s_q.nvalid || bus.note_ready) begin
      case (s_q.emit)
        RPDN_B0: begin
          s_d.nvalid = 1'b1;
          s_d.nbyte = s_q.emit_port ? RPDN_PORT_LEN : RPDN_WAKE_LEN;
          s_d.nlast = 1'b0;
          s_d.emit = RPDN_B1;
        end
        RPDN_B1: begin
          s_d.nvalid = 1'b1;
          s_d.nbyte = s_q.emit_port ? RPDN_PORT_CODE : RPDN_WAKE_CODE;
          s_d.nlast = !s_q.emit_port;
          s_d.emit = s_q.emit_port ? RPDN_B2 : RPDN_IDLE;
        end
        RPDN_B2: begin
          s_d.nvalid = 1'b1;
          s_d.nbyte = s_q.emit_idx;
          s_d.nlast = 1'b1;
          s_d.emit = RPDN_IDLE;
        end
        default: begin
          // Idle: a block start chosen above must stand, so nothing is assigned here.
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register.
  assign bus.desc_rdata = s_q.rdata;
  assign bus.note_valid = s_q.nvalid;
  assign bus.note_byte = s_q.nbyte;
  assign bus.note_last = s_q.nlast;
  assign o_retry_limit = s_q.retry_o;
  assign o_count_errors = s_q.cnt_o;
  assign o_result_ep = s_q.ep_o;
  assign o_use_default_ep = s_q.def_o;
  assign o_behind_mtt = s_q.mtt_o;
  assign o_vendor_word = s_q.vend;

endmodule : rpdn_dev
`default_nettype wire

//--- src/rpdn_pkg.sv
// Package for the remote pipe descriptor tail and notification logic.
// Assumes one clock and one asynchronous reset shared by both ends.
package rpdn_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor byte offsets.
  localparam logic [7:0] RPDN_OFF_CAPS = 8'h18;
  localparam logic [7:0] RPDN_OFF_RETRY = 8'h19;
  localparam logic [7:0] RPDN_OFF_ERR_LO = 8'h1A;
  localparam logic [7:0] RPDN_OFF_ERR_HI = 8'h1B;
  localparam logic [7:0] RPDN_OFF_VEND_LO = 8'h1C;
  localparam logic [7:0] RPDN_OFF_VEND_HI = 8'h1D;
  localparam logic [7:0] RPDN_OFF_RES_EP = 8'h1E;
  localparam logic [7:0] RPDN_OFF_ATTR = 8'h17;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and widths.
  localparam int RPDN_CAP_CTRL = 0;
  localparam int RPDN_CAP_ISO = 1;
  localparam int RPDN_CAP_BULK = 2;
  localparam int RPDN_CAP_INTR = 3;
  localparam int RPDN_CAP_TRANSP = 4;
  localparam int RPDN_ATTR_MTT = 7;
  localparam logic [7:0] RPDN_RETRY_MASK = 8'h07;
  localparam logic [2:0] RPDN_RETRY_MAX = 3'h3;
  localparam logic [4:0] RPDN_CAP_MASK = 5'h1F;
  localparam logic [7:0] RPDN_ATTR_TYPE_MASK = 8'h03;
  localparam logic [7:0] RPDN_TYPE_ISO = 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and other constants.
  localparam logic [7:0] RPDN_RST_BYTE = 8'h00;
  localparam logic [15:0] RPDN_RST_WORD = 16'h0000;
  localparam logic [15:0] RPDN_ERR_SAT = 16'hFFFF;
  localparam logic [15:0] RPDN_ONE16 = 16'h0001;
  localparam logic [1:0] RPDN_ONE2 = 2'h1;
  localparam logic [1:0] RPDN_ZERO2 = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Notification block bytes.
  localparam logic [7:0] RPDN_WAKE_LEN = 8'h02;
  localparam logic [7:0] RPDN_WAKE_CODE = 8'h91;
  localparam logic [7:0] RPDN_PORT_LEN = 8'h03;
  localparam logic [7:0] RPDN_PORT_CODE = 8'h92;

  ////////////////////////////////////////////////////////////////////////////
  // Host register map (byte offsets of the host's own command port).
  localparam logic [3:0] RPDN_H_CMD = 4'h0;  // Write: [15:8] offset, [7:0] data, bit16 write.
  localparam logic [3:0] RPDN_H_RDATA = 4'h4;  // Read: last read byte, bit8 busy.
  localparam logic [3:0] RPDN_H_NOTE = 4'h8;  // Read: last notice byte, bit8 valid.
  localparam int RPDN_CMD_WR = 16;

  typedef enum logic [1:0] {RPDN_IDLE, RPDN_B0, RPDN_B1, RPDN_B2} rpdn_emit_e;

endpackage : rpdn_pkg

//--- src/rpdn_if.sv
// Interface joining the descriptor host end and the adapter end.
// Assumes both ends share one clock; the descriptor port answers a read in one cycle.
`timescale 1ns/100ps
`default_nettype none
interface rpdn_if;
  logic desc_wr;
  logic desc_rd;
  logic [7:0] desc_addr;
  logic [7:0] desc_wdata;
  logic [7:0] desc_rdata;
  logic note_valid;
  logic note_ready;
  logic [7:0] note_byte;
  logic note_last;
  modport dev (input desc_wr, desc_rd, desc_addr, desc_wdata, note_ready,
               output desc_rdata, note_valid, note_byte, note_last);
  modport host (output desc_wr, desc_rd, desc_addr, desc_wdata, note_ready,
                input desc_rdata, note_valid, note_byte, note_last);
endinterface : rpdn_if
`default_nettype wire

//--- src/rpdn_host.sv
// Host end: turns software register accesses into descriptor port cycles.
// Assumes the adapter end answers a descriptor read in the next cycle.
`timescale 1ns/100ps
`default_nettype none
module rpdn_host (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  rpdn_if.host bus,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_mtt_supported,
  output logic [31:0] o_rdata
);
  import rpdn_pkg::*;

  typedef struct packed {
    logic dwr;
    logic drd;
    logic [7:0] daddr;
    logic [7:0] dwdata;
    logic pend;
    logic [7:0] rbyte;
    logic [7:0] nbyte;
    logic nvalid;
    logic iso_pipe;
    logic [31:0] rdata;
  } rpdn_host_s;

  rpdn_host_s s_q;
  rpdn_host_s s_d;

  //////////////////////////////////////////////////////////////////////////////
  // Command decode, descriptor cycles and software reads.
  always_comb begin
    s_d = s_q;
    s_d.dwr = 1'b0;
    s_d.drd = 1'b0;
    s_d.rdata = 32'h0000_0000;
    if (s_q.pend) begin
      s_d.rbyte = bus.desc_rdata;
      s_d.pend = 1'b0;
    end
    if (s_q.drd) begin
      s_d.pend = 1'b1;
    end
    if (i_wr && i_addr == RPDN_H_CMD) begin
      s_d.daddr = i_wdata[15:8];
      s_d.dwdata = i_wdata[7:0];
      // Clear the multi translator bit when the adapter lacks support.
      if (i_wdata[15:8] == RPDN_OFF_ATTR && !i_mtt_supported) begin
        s_d.dwdata[RPDN_ATTR_MTT] = 1'b0;
      end
      // Isochronous pipes get a zero retry limit; the type comes from attribute writes.
      if (i_wdata[15:8] == RPDN_OFF_RETRY && s_q.iso_pipe) begin
        s_d.dwdata = i_wdata[7:0] & ~RPDN_RETRY_MASK;
      end
      if (i_wdata[15:8] == RPDN_OFF_ATTR && i_wdata[RPDN_CMD_WR]) begin
        s_d.iso_pipe = ((i_wdata[7:0] & RPDN_ATTR_TYPE_MASK) == RPDN_TYPE_ISO);
      end
      s_d.dwr = i_wdata[RPDN_CMD_WR];
      s_d.drd = !i_wdata[RPDN_CMD_WR];
    end
    if (bus.note_valid) begin
      s_d.nbyte = bus.note_byte;
      s_d.nvalid = 1'b1;
    end
    if (i_rd) begin
      if (i_addr == RPDN_H_RDATA) begin
        s_d.rdata = {23'h0, s_q.drd | s_q.pend, s_q.rbyte};
      end else if (i_addr == RPDN_H_NOTE) begin
        s_d.rdata = {23'h0, s_q.nvalid, s_q.nbyte};
        s_d.nvalid = bus.note_valid; // New byte wins over the read clear.
      end else begin
        s_d.rdata = 32'h0000_0000;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs from the state register; notice bytes are always accepted.
  assign bus.desc_wr = s_q.dwr;
  assign bus.desc_rd = s_q.drd;
  assign bus.desc_addr = s_q.daddr;
  assign bus.desc_wdata = s_q.dwdata;
  assign bus.note_ready = 1'b1;
  assign o_rdata = s_q.rdata;

endmodule : rpdn_host
`default_nettype wire

//--- tb/rpdn_asserts.sv
// Checker on the wires between the host end and the adapter end.
// Assumes it sits beside the interface, with one clock and reset high.
`timescale 1ns/100ps
`default_nettype none
module rpdn_asserts (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic desc_wr,
  input wire logic desc_rd,
  input wire logic [7:0] desc_addr,
  input wire logic [7:0] desc_wdata,
  input wire logic [7:0] desc_rdata,
  input wire logic note_valid,
  input wire logic note_ready,
  input wire logic [7:0] note_byte,
  input wire logic note_last
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  logic first_q, rdc_q, seen_q;
  logic [7:0] caps_q;
  wire logic acc = note_valid && note_ready;
  ////////////////////////////////////////////////////////////////////////////
  // Marks block starts and keeps the last capability byte read back.
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      first_q <= 1'b1;
      rdc_q <= 1'b0;
      seen_q <= 1'b0;
      caps_q <= 8'h00;
    end else begin
      if (acc) first_q <= note_last;
      rdc_q <= desc_rd && (desc_addr == 8'h18);
      seen_q <= seen_q || rdc_q;
      if (rdc_q) caps_q <= desc_rdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // A block opens with its length byte, never with a last byte.
  property p_start; note_valid && first_q |-> note_byte inside {8'h02, 8'h03} && !note_last;
  endproperty
  a_start: assert property (p_start) else $error("bad block start");
  property p_wake; acc && first_q && note_byte == 8'h02 |=> acc && note_byte == 8'h91 && note_last;
  endproperty
  a_wake: assert property (p_wake) else $error("bad wake block");
  property p_port; acc && first_q && note_byte == 8'h03 |=>
    acc && note_byte == 8'h92 && !note_last ##1 acc && note_last; endproperty
  a_port: assert property (p_port) else $error("bad port block");
  // Descriptor read answers.
  property p_caps_rsvd; desc_rd && desc_addr == 8'h18 |=> desc_rdata[7:5] == 3'h0; endproperty
  a_caps_rsvd: assert property (p_caps_rsvd) else $error("caps reserved set");
  property p_caps_ro; rdc_q && seen_q |-> desc_rdata == caps_q; endproperty
  a_caps_ro: assert property (p_caps_ro) else $error("caps byte changed");
  property p_retry_rsvd; desc_rd && desc_addr == 8'h19 |=> desc_rdata[7:3] == 5'h00; endproperty
  a_retry_rsvd: assert property (p_retry_rsvd) else $error("retry reserved set");
  property p_unmapped; desc_rd && desc_addr > 8'h1E |=> desc_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  property p_stand; !desc_rd |=> $stable(desc_rdata); endproperty
  a_stand: assert property (p_stand) else $error("read data moved");
  c_wake: cover property (acc && first_q && note_byte == 8'h02);
  c_port: cover property (acc && first_q && note_byte == 8'h03);
  c_caps: cover property (rdc_q && seen_q);
endmodule : rpdn_asserts
`default_nettype wire

//--- tb/rpdn_tb_top.sv
// Testbench joining the host end and the adapter end through the interface.
// Assumes package, interface, both ends and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("Error t=%0t got=%h exp=%h", $time, (a), (b)); end end
module rpdn_tb_top;
  import rpdn_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [4:0] caps = 5'h00;
  logic armed = 1'b0, wake = 1'b0, pchg = 1'b0, terr = 1'b0, hs = 1'b0, msup = 1'b1, hub = 1'b1;
  logic [7:0] pidx = 8'h00, eps = 8'h00, rep, q;
  logic [7:0] w [6];
  logic [2:0] rlim;
  logic cnt_en, use_def, mtt, hwr = 1'b0, hrd = 1'b0;
  logic [15:0] vend;
  logic [3:0] haddr = 4'h0;
  logic [31:0] hwdata = 32'h0, hrdata;
  logic [8:0] nq [$], eq [$];
  int n_errors = 0, n_checks = 0, seed;
  rpdn_if bus_if ();
  rpdn_dev rpdn_dev_inst (.i_clk_sys, .i_sys_rst, .bus(bus_if), .i_caps(caps),
    .i_wake_armed(armed), .i_wake_event(wake), .i_port_change(pchg), .i_port_index(pidx),
    .i_txn_error(terr), .i_hs_hub_nonzero(hub), .i_high_speed(hs), .i_result_eps(eps),
    .o_retry_limit(rlim), .o_count_errors(cnt_en), .o_result_ep(rep),
    .o_use_default_ep(use_def), .o_behind_mtt(mtt), .o_vendor_word(vend));
  rpdn_host rpdn_host_inst (.i_clk_sys, .i_sys_rst, .bus(bus_if), .i_addr(haddr),
    .i_wdata(hwdata), .i_wr(hwr), .i_rd(hrd), .i_mtt_supported(msup), .o_rdata(hrdata));
  rpdn_asserts rpdn_asserts_inst (.i_clk_sys, .i_sys_rst, .desc_wr(bus_if.desc_wr),
    .desc_rd(bus_if.desc_rd), .desc_addr(bus_if.desc_addr), .desc_wdata(bus_if.desc_wdata),
    .desc_rdata(bus_if.desc_rdata), .note_valid(bus_if.note_valid),
    .note_ready(bus_if.note_ready), .note_byte(bus_if.note_byte),
    .note_last(bus_if.note_last));
  ////////////////////////////////////////////////////////////////////////////
  // Clock, notice collector and run limit.
  initial begin
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    if (bus_if.note_valid && bus_if.note_ready)
      nq.push_back({bus_if.note_last, bus_if.note_byte});
  end
  initial begin
    repeat (100000) @(posedge i_clk_sys);
    n_errors++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////////
  // One software access; read data is taken at the edge closing the cycle after the strobe.
  task automatic sw(input logic wr, input logic [3:0] a, input logic [31:0] v);
    @(posedge i_clk_sys);
    haddr <= a;
    hwdata <= v;
    hwr <= wr;
    hrd <= !wr;
    @(posedge i_clk_sys);
    hwr <= 1'b0;
    hrd <= 1'b0;
    @(posedge i_clk_sys);
  endtask : sw
  // One descriptor access, polling busy under a bound; the read byte lands in q.
  task automatic desc(input logic wr, input logic [7:0] a, input logic [7:0] v);
    int i;
    sw(1'b1, RPDN_H_CMD, {15'h0, wr, a, v});
    repeat (3) @(posedge i_clk_sys);
    for (i = 0; i < 20; i++) begin
      sw(1'b0, RPDN_H_RDATA, 32'h0);
      if (hrdata[8] === 1'b0) break;
    end
    q = hrdata[7:0];
    if (i == 20) begin
      n_errors++;
      summarize();
    end
  endtask : desc
  // Pulses {error, port change, wake} n times with a gap between pulses.
  task automatic pulse(input logic [2:0] m, input int n);
    repeat (n) begin
      @(posedge i_clk_sys);
      {terr, pchg, wake} <= m;
      @(posedge i_clk_sys);
      {terr, pchg, wake} <= 3'h0;
    end
  endtask : pulse
  // Waits for the expected notice bytes, then lets any extra ones show.
  task automatic notes();
    int i;
    for (i = 0; i < 30 && nq.size() < eq.size(); i++) @(posedge i_clk_sys);
    repeat (10) @(posedge i_clk_sys);
    `CK(nq.size(), eq.size())
    foreach (eq[j]) if (j < nq.size()) `CK(nq[j], eq[j])
    nq.delete();
    eq.delete();
  endtask : notes
  // Expected fallback to the default results endpoint.
  function automatic logic dflt(input logic [7:0] e, input logic tr);
    return (e == 8'h00) || tr || !eps[e[2:0]];
  endfunction : dflt
  task automatic summarize();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, then fields, caps, retry, errors, endpoint, notices, attribute.
  initial begin
    seed = 32'h0ecfb7a7;
    caps = 5'($random(seed));
    eps = 8'($random(seed));
    repeat (5) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      w[k] = 8'($random(seed));
      desc(1'b1, 8'(8'h19 + k), w[k]);
      desc(1'b0, 8'(8'h19 + k), 8'h00);
      `CK(q, (k == 0) ? (w[k] & RPDN_RETRY_MASK) : w[k])
    end
    `CK(vend, {w[4], w[3]})
    desc(1'b0, 8'h20, 8'h00);
    `CK(q, 8'h00)
    desc(1'b0, RPDN_OFF_CAPS, 8'h00);
    `CK(q, {3'h0, caps})
    desc(1'b1, RPDN_OFF_CAPS, ~q);
    desc(1'b0, RPDN_OFF_CAPS, 8'h00);
    `CK(q, {3'h0, caps})
    $display("test fields done");
    for (int v = 0; v < 8; v++) begin
      desc(1'b1, RPDN_OFF_RETRY, 8'(v));
      `CK(rlim, (v > 3) ? 3'h3 : 3'(v))
      `CK(cnt_en, v != 0)
    end
    desc(1'b1, RPDN_OFF_RETRY, 8'h00);
    desc(1'b1, RPDN_OFF_ERR_LO, 8'h00);
    desc(1'b1, RPDN_OFF_ERR_HI, 8'h00);
    pulse(3'h4, 4);
    desc(1'b0, RPDN_OFF_ERR_LO, 8'h00);
    `CK(q, 8'h00)
    desc(1'b1, RPDN_OFF_RETRY, 8'h02);
    pulse(3'h4, 5);
    desc(1'b0, RPDN_OFF_ERR_LO, 8'h00);
    `CK(q, 8'h05)
    desc(1'b1, RPDN_OFF_ERR_LO, 8'hFE);
    desc(1'b1, RPDN_OFF_ERR_HI, 8'hFF);
    pulse(3'h4, 3);
    desc(1'b0, RPDN_OFF_ERR_LO, 8'h00);
    `CK(q, 8'hFF)
    $display("test errors done");
    for (int t = 0; t < 2; t++) begin
      caps[4] <= t[0];
      for (int e = 0; e < 8; e++) begin
        desc(1'b1, RPDN_OFF_RES_EP, 8'(e));
        `CK(use_def, dflt(8'(e), t[0]))
        `CK(rep, dflt(8'(e), t[0]) ? 8'h00 : 8'(e))
      end
    end
    $display("test endpoint done");
    pulse(3'h1, 1);
    notes();
    armed <= 1'b1;
    pulse(3'h1, 1);
    eq = '{9'h002, 9'h191};
    notes();
    pidx <= 8'($random(seed));
    pulse(3'h3, 1);
    eq = '{9'h002, 9'h191, 9'h003, 9'h092, {1'b1, pidx}};
    notes();
    sw(1'b0, RPDN_H_NOTE, 32'h0);
    `CK(hrdata[8:0], {1'b1, pidx})
    $display("test notices done");
    desc(1'b1, RPDN_OFF_ATTR, 8'h80);
    `CK(mtt, 1'b1)
    hs <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    `CK(mtt, 1'b0)
    hs <= 1'b0;
    hub <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    `CK(mtt, 1'b0)
    hub <= 1'b1;
    msup <= 1'b0;
    desc(1'b1, RPDN_OFF_ATTR, 8'h80);
    `CK(mtt, 1'b0)
    desc(1'b1, RPDN_OFF_ATTR, 8'h01);
    desc(1'b1, RPDN_OFF_RETRY, 8'h03);
    `CK(rlim, 3'h0)
    `CK(cnt_en, 1'b0)
    $display("test attribute done");
    summarize();
  end
endmodule : rpdn_tb_top
`default_nettype wire
